// ### fsc_bus_monitor.sv
// Samples the control port lines and reports start, stop and clock edges.
`timescale 1ns/10ps
module fsc_bus_monitor (
	input  wire logic                clk,
	input  wire logic                reset,
	input  wire logic                sclIn,
	input  wire logic                sdaIn,
	output fsc_pkg::fsc_bus_ev_t     busEv
);
	import fsc_pkg::*;

	logic sclPrev_reg;
	logic sdaPrev_reg;

	// Previous line levels; idle bus lines rest high.
	always_ff @(posedge clk) begin
		if (reset) begin
			sclPrev_reg <= 1'b1;
			sdaPrev_reg <= 1'b1;
		end else begin
			sclPrev_reg <= sclIn;
			sdaPrev_reg <= sdaIn;
		end
	end

	// Data changing while the clock stays high marks start or stop.
	assign busEv.start   = sclIn & sclPrev_reg & sdaPrev_reg & ~sdaIn;
	assign busEv.stop    = sclIn & sclPrev_reg & ~sdaPrev_reg & sdaIn;
	assign busEv.sclRise = sclIn & ~sclPrev_reg;
	assign busEv.sclFall = ~sclIn & sclPrev_reg;
	assign busEv.sda     = sdaIn;

endmodule : fsc_bus_monitor

// ### fsc_fault_latch.sv
// One latching fault flag that holds until shutdown clears it.
`timescale 1ns/10ps
module fsc_fault_latch (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic detect,
	input  wire logic clear,
	output logic      flag
);
	logic flag_reg;
	logic flag_next;

	// A detection in the clearing cycle wins, so no event is lost.
	assign flag_next = detect | (flag_reg & ~clear);

	// Flag register, zero after reset.
	always_ff @(posedge clk) begin
		if (reset) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

	assign flag = flag_reg;

endmodule : fsc_fault_latch

// ### fsc_host_model.sv
// Host processor model driving the control port as bus master.
`timescale 1ns/10ps
module fsc_host_model (
	input  wire logic       clk,
	input  wire logic [6:0] devAddr,
	input  wire logic       sdaLine,
	output logic            scl,
	output logic            sdaLow
);
	import fsc_pkg::*;
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	// Five cycles a half keeps above the four the port needs.
	task automatic half();
		repeat (5) @(posedge clk);
		#1;
	endtask : half
	// Data moves one cycle after the clock falls, so the device never sees both change together.
	task automatic xfer(input logic b, output logic got);
		@(posedge clk);
		#1;
		sdaLow = !b;
		half();
		scl = 1'b1;
		half();
		got = sdaLine;
		scl = 1'b0;
	endtask : xfer
	// Serves as start and as repeated start: data released while the clock is low, then pulled low while it is high.
	task automatic start();
		@(posedge clk);
		#1;
		sdaLow = 1'b0;
		half();
		scl = 1'b1;
		half();
		sdaLow = 1'b1;
		half();
		scl = 1'b0;
	endtask : start
	// Data is pulled low under a low clock, then released while the clock is high; the bus is left idle.
	task automatic stop();
		@(posedge clk);
		#1;
		sdaLow = 1'b1;
		half();
		scl = 1'b1;
		half();
		sdaLow = 1'b0;
		half();
	endtask : stop
	task automatic sendByte(input logic [7:0] v, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) xfer(v[i], g);
		xfer(1'b1, g);
		ack = !g;
	endtask : sendByte
	// The final released ninth bit is the not-acknowledge that ends a read.
	task automatic getByte(output logic [7:0] v);
		logic g;
		for (int i = 8; i >= 0; i--) begin
			xfer(1'b1, g);
			if (i > 0) v[i-1] = g;
		end
	endtask : getByte
	task automatic writeReg(input logic [7:0] a, input logic [7:0] d, output logic ok);
		logic k1, k2, k3;
		ok = 1'b0;
		if (a >= FSC_ADDR_RSVD_LO && a <= FSC_ADDR_RSVD_HI) return;
		if (a == FSC_ADDR_FAULT) d[7:6] = 2'h0;
		if (a == FSC_ADDR_CLIP_LOW) d[1:0] = 2'h0;
		start();
		sendByte({devAddr, 1'b0}, k1);
		sendByte(a, k2);
		sendByte(d, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask : writeReg
	task automatic readReg(input logic [7:0] a, output logic [7:0] d, output logic ok);
		logic k1, k2, k3;
		start();
		sendByte({devAddr, 1'b0}, k1);
		sendByte(a, k2);
		start();
		sendByte({devAddr, 1'b1}, k3);
		getByte(d);
		stop();
		ok = k1 & k2 & k3;
	endtask : readReg
endmodule : fsc_host_model

// ### fsc_pkg.sv
// Shared constants and types for the fault status and clip threshold registers.
package fsc_pkg;

	// Register offsets on the control port.
	localparam logic [7:0] FSC_ADDR_FAULT    = 8'h08;
	localparam logic [7:0] FSC_ADDR_RSVD_LO  = 8'h09;
	localparam logic [7:0] FSC_ADDR_RSVD_HI  = 8'h0f;
	localparam logic [7:0] FSC_ADDR_CLIP_MID = 8'h10;
	localparam logic [7:0] FSC_ADDR_CLIP_LOW = 8'h11;

	// Field positions inside the fault and clip low registers.
	localparam int FSC_TRIP_MSB   = 5;
	localparam int FSC_TRIP_LSB   = 4;
	localparam int FSC_CLKF_BIT   = 3;
	localparam int FSC_OCF_BIT    = 2;
	localparam int FSC_DCF_BIT    = 1;
	localparam int FSC_OTF_BIT    = 0;
	localparam int FSC_CLIP_LOW_LSB = 2;

	// Reset values, and the value read from unmapped offsets.
	localparam logic [1:0] FSC_TRIP_RST     = 2'h0;
	localparam logic [7:0] FSC_CLIP_MID_RST = 8'h01;
	localparam logic [7:0] FSC_CLIP_LOW_RST = 8'h04;
	localparam logic [7:0] FSC_READ_UNMAPPED = 8'h00;

	// Widths of the current sense path and the clip threshold.
	localparam int FSC_CUR_W       = 12;
	localparam int FSC_CLIP_W      = 20;
	localparam int FSC_CLIP_HIGH_W = 6;
	localparam logic [FSC_CUR_W-1:0] FSC_OC_NOMINAL = 12'h800;

	// Trip level scaling codes.
	typedef enum logic [1:0] {
		FSC_TRIP_FULL = 2'b00,
		FSC_TRIP_75   = 2'b01,
		FSC_TRIP_50   = 2'b10,
		FSC_TRIP_25   = 2'b11
	} fsc_trip_t;

	// Serial control port engine states.
	typedef enum logic [2:0] {
		FSC_ST_IDLE  = 3'b000,
		FSC_ST_ADDR  = 3'b001,
		FSC_ST_RECV  = 3'b010,
		FSC_ST_ACK1  = 3'b011,
		FSC_ST_ACK2  = 3'b100,
		FSC_ST_SEND  = 3'b101,
		FSC_ST_RACK  = 3'b110,
		FSC_ST_RNEXT = 3'b111
	} fsc_state_t;

	// Bus line events seen on the control port.
	typedef struct packed {
		logic start;
		logic stop;
		logic sclRise;
		logic sclFall;
		logic sda;
	} fsc_bus_ev_t;

	// One register write from the control port.
	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} fsc_wr_req_t;

	// Fault status flags as seen by software.
	typedef struct packed {
		logic clockFaultFlag;
		logic overcurrentFaultFlag;
		logic outputDcFaultFlag;
		logic overtempFaultFlag;
	} fsc_fault_t;

endpackage : fsc_pkg

// ### fsc_regs.sv
// Control port engine plus fault, trip level and clip threshold registers.
`timescale 1ns/10ps
module fsc_regs (
	input  wire logic                                  clk,
	input  wire logic                                  reset,
	input  wire logic                                  sclIn,
	input  wire logic                                  sdaIn,
	output logic                                       sdaOut,
	output logic                                       sdaOe,
	input  wire logic [6:0]                            deviceAddress,
	input  wire logic                                  ampShutdownPinN,
	input  wire logic                                  ampShutdownBit,
	input  wire logic                                  clockErrorDetect,
	input  wire logic [fsc_pkg::FSC_CUR_W-1:0]         outputCurrent,
	input  wire logic                                  outputDcDetect,
	input  wire logic                                  overtempDetect,
	input  wire logic [fsc_pkg::FSC_CLIP_HIGH_W-1:0]   clipThresholdHigh,
	output fsc_pkg::fsc_fault_t                        faultStatus,
	output logic [fsc_pkg::FSC_CUR_W-1:0]              overcurrentTripLevel,
	output logic [fsc_pkg::FSC_CLIP_W-1:0]             clipThresholdValue,
	output logic                                       ampHalt
);
	import fsc_pkg::*;

	// Scales the nominal trip current by the programmed code.
	function automatic logic [FSC_CUR_W-1:0] tripScale(input logic [1:0] code);
		logic [FSC_CUR_W-1:0] quarter;
		quarter = FSC_OC_NOMINAL >> 2;
		case (code)
			FSC_TRIP_75: tripScale = FSC_OC_NOMINAL - quarter;
			FSC_TRIP_50: tripScale = FSC_OC_NOMINAL >> 1;
			FSC_TRIP_25: tripScale = quarter;
			default:     tripScale = FSC_OC_NOMINAL;
		endcase
	endfunction : tripScale

	fsc_bus_ev_t busEv;
	fsc_state_t  state_reg;
	logic [2:0]  bitCnt_reg;
	logic [7:0]  shift_reg;
	logic [7:0]  ptr_reg;
	logic        isRead_reg;
	logic        gotPtr_reg;
	logic        sdaOe_reg;
	logic        sdaOut_reg;
	fsc_wr_req_t wrReq_reg;

	logic [7:0]  rxByte;
	logic        byteLast;
	logic        addrMatch;
	logic [7:0]  rdData;

	logic [1:0]  tripCode_reg;
	logic [7:0]  clipMid_reg;
	logic [7:0]  clipLow_reg;
	logic        clockFaultFlag_reg;
	logic [FSC_CUR_W-1:0]  tripLevel_reg;
	logic [FSC_CLIP_W-1:0] clipValue_reg;
	logic        ampHalt_reg;
	logic        overcurrentLatched;
	logic        outputDcLatched;
	logic        overtempLatched;

	logic        shutdownActive;
	logic        overcurrentEvent;
	logic        wrFault;
	logic        wrClipMid;
	logic        wrClipLow;
	logic        wrReserved;
	logic [7:0]  faultByte;

	// Line sampling and event detection.
	fsc_bus_monitor busMon (
		.clk   (clk),
		.reset (reset),
		.sclIn (sclIn),
		.sdaIn (sdaIn),
		.busEv (busEv)
	);

	// Byte assembly and address match for the serial engine.
	assign rxByte    = {shift_reg[6:0], busEv.sda};
	assign byteLast  = (bitCnt_reg == 3'h7);
	assign addrMatch = (rxByte[7:1] == deviceAddress);

	// Serial engine state: start and stop override every state.
	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= FSC_ST_IDLE;
		end else if (busEv.start) begin
			state_reg <= FSC_ST_ADDR;
		end else if (busEv.stop) begin
			state_reg <= FSC_ST_IDLE;
		end else begin
			case (state_reg)
				FSC_ST_ADDR: begin
					if (busEv.sclRise && byteLast) begin
						state_reg <= addrMatch ? FSC_ST_ACK1 : FSC_ST_IDLE;
					end
				end
				FSC_ST_RECV: begin
					if (busEv.sclRise && byteLast) begin
						state_reg <= FSC_ST_ACK1;
					end
				end
				FSC_ST_ACK1: begin
					if (busEv.sclFall) begin
						state_reg <= FSC_ST_ACK2;
					end
				end
				FSC_ST_ACK2: begin
					if (busEv.sclFall) begin
						state_reg <= isRead_reg ? FSC_ST_SEND : FSC_ST_RECV;
					end
				end
				FSC_ST_SEND: begin
					if (busEv.sclFall && byteLast) begin
						state_reg <= FSC_ST_RACK;
					end
				end
				FSC_ST_RACK: begin
					if (busEv.sclRise) begin
						// A high bit here is a not-acknowledge that ends the read.
						state_reg <= busEv.sda ? FSC_ST_IDLE : FSC_ST_RNEXT;
					end
				end
				FSC_ST_RNEXT: begin
					if (busEv.sclFall) begin
						state_reg <= FSC_ST_SEND;
					end
				end
				default: begin
					state_reg <= FSC_ST_IDLE;
				end
			endcase
		end
	end

	// Bit counter and shift register for both directions.
	always_ff @(posedge clk) begin
		if (reset || busEv.start) begin
			bitCnt_reg <= 3'h0;
			shift_reg  <= 8'h00;
		end else if ((state_reg == FSC_ST_ADDR || state_reg == FSC_ST_RECV) && busEv.sclRise) begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
			shift_reg  <= rxByte;
		end else if ((state_reg == FSC_ST_ACK2 && isRead_reg && busEv.sclFall) ||
				(state_reg == FSC_ST_RNEXT && busEv.sclFall)) begin
			bitCnt_reg <= 3'h0;
			shift_reg  <= rdData;
		end else if (state_reg == FSC_ST_SEND && busEv.sclFall) begin
			bitCnt_reg <= bitCnt_reg + 3'h1;
			shift_reg  <= {shift_reg[6:0], 1'b0};
		end else if (state_reg == FSC_ST_ACK2 && busEv.sclFall) begin
			bitCnt_reg <= 3'h0;
		end
	end

	// Direction bit and pointer-received flag for each transfer.
	always_ff @(posedge clk) begin
		if (reset) begin
			isRead_reg <= 1'b0;
			gotPtr_reg <= 1'b0;
		end else if (busEv.start) begin
			gotPtr_reg <= 1'b0;
		end else if (state_reg == FSC_ST_ADDR && busEv.sclRise && byteLast) begin
			isRead_reg <= rxByte[0];
		end else if (state_reg == FSC_ST_RECV && busEv.sclRise && byteLast) begin
			gotPtr_reg <= 1'b1;
		end
	end

	// Register pointer: first written byte loads it, every data byte advances it.
	always_ff @(posedge clk) begin
		if (reset) begin
			ptr_reg <= 8'h00;
		end else if (state_reg == FSC_ST_RECV && busEv.sclRise && byteLast) begin
			ptr_reg <= gotPtr_reg ? ptr_reg + 8'h01 : rxByte;
		end else if (state_reg == FSC_ST_SEND && busEv.sclFall && byteLast) begin
			ptr_reg <= ptr_reg + 8'h01;
		end
	end

	// Write request pulse, one cycle per received data byte.
	always_ff @(posedge clk) begin
		if (reset) begin
			wrReq_reg <= '0;
		end else begin
			wrReq_reg.valid <= (state_reg == FSC_ST_RECV) && busEv.sclRise && byteLast && gotPtr_reg;
			wrReq_reg.addr  <= ptr_reg;
			wrReq_reg.data  <= rxByte;
		end
	end

	// Open-drain data line: only ever pulled low, changed on clock falls so data is stable while high.
	always_ff @(posedge clk) begin
		if (reset || busEv.start || busEv.stop) begin
			sdaOe_reg <= 1'b0;
		end else if (busEv.sclFall) begin
			case (state_reg)
				FSC_ST_ACK1:  sdaOe_reg <= 1'b1;
				FSC_ST_ACK2:  sdaOe_reg <= isRead_reg & ~rdData[7];
				FSC_ST_SEND:  sdaOe_reg <= byteLast ? 1'b0 : ~shift_reg[6];
				FSC_ST_RNEXT: sdaOe_reg <= ~rdData[7];
				default:      sdaOe_reg <= 1'b0;
			endcase
		end
	end

	// The driven level is always low; only the enable moves.
	always_ff @(posedge clk) begin
		sdaOut_reg <= 1'b0;
	end

	// Write decode; reserved and unknown offsets take no write.
	assign wrFault    = wrReq_reg.valid && (wrReq_reg.addr == FSC_ADDR_FAULT);
	assign wrClipMid  = wrReq_reg.valid && (wrReq_reg.addr == FSC_ADDR_CLIP_MID);
	assign wrClipLow  = wrReq_reg.valid && (wrReq_reg.addr == FSC_ADDR_CLIP_LOW);
	assign wrReserved = (wrReq_reg.addr >= FSC_ADDR_RSVD_LO) && (wrReq_reg.addr <= FSC_ADDR_RSVD_HI);

	// Programmable registers; status bits of the fault register are not stored.
	always_ff @(posedge clk) begin
		if (reset) begin
			tripCode_reg <= FSC_TRIP_RST;
			clipMid_reg  <= FSC_CLIP_MID_RST;
			clipLow_reg  <= FSC_CLIP_LOW_RST;
		end else begin
			if (wrFault && !wrReserved) begin
				tripCode_reg <= wrReq_reg.data[FSC_TRIP_MSB:FSC_TRIP_LSB];
			end
			if (wrClipMid) begin
				clipMid_reg <= wrReq_reg.data;
			end
			if (wrClipLow) begin
				clipLow_reg <= wrReq_reg.data;
			end
		end
	end

	assign shutdownActive = ~ampShutdownPinN | ~ampShutdownBit;

	assign overcurrentEvent = (outputCurrent > tripLevel_reg);

	// Trip level is registered so the comparator sees a clean value.
	always_ff @(posedge clk) begin
		if (reset) begin
			tripLevel_reg <= FSC_OC_NOMINAL;
		end else begin
			tripLevel_reg <= tripScale(tripCode_reg);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			clockFaultFlag_reg <= 1'b0;
		end else begin
			clockFaultFlag_reg <= clockErrorDetect;
		end
	end

	fsc_fault_latch ocLatch (
		.clk    (clk),
		.reset  (reset),
		.detect (overcurrentEvent),
		.clear  (shutdownActive),
		.flag   (overcurrentLatched)
	);

	fsc_fault_latch dcLatch (
		.clk    (clk),
		.reset  (reset),
		.detect (outputDcDetect),
		.clear  (shutdownActive),
		.flag   (outputDcLatched)
	);

	fsc_fault_latch otLatch (
		.clk    (clk),
		.reset  (reset),
		.detect (overtempDetect),
		.clear  (shutdownActive),
		.flag   (overtempLatched)
	);

	assign faultStatus.clockFaultFlag       = clockFaultFlag_reg;
	assign faultStatus.overcurrentFaultFlag = overcurrentLatched;
	assign faultStatus.outputDcFaultFlag    = outputDcLatched;
	assign faultStatus.overtempFaultFlag    = overtempLatched;

	assign faultByte = {2'b00, tripCode_reg, clockFaultFlag_reg, overcurrentLatched,
		outputDcLatched, overtempLatched};

	// Read mux; anything unmapped, the reserved range included, reads as zero.
	assign rdData = (ptr_reg == FSC_ADDR_FAULT)    ? faultByte :
			(ptr_reg == FSC_ADDR_CLIP_MID) ? clipMid_reg :
			(ptr_reg == FSC_ADDR_CLIP_LOW) ? clipLow_reg :
			FSC_READ_UNMAPPED;

	always_ff @(posedge clk) begin
		if (reset) begin
			clipValue_reg <= '0;
		end else begin
			clipValue_reg <= {clipThresholdHigh, clipMid_reg, clipLow_reg[7:FSC_CLIP_LOW_LSB]};
		end
	end

	// Output stage is halted in shutdown, on a clock error, or by any latched fault.
	always_ff @(posedge clk) begin
		if (reset) begin
			ampHalt_reg <= 1'b1;
		end else begin
			ampHalt_reg <= shutdownActive | clockFaultFlag_reg | overcurrentLatched |
				outputDcLatched | overtempLatched;
		end
	end

	assign sdaOut               = sdaOut_reg;
	assign sdaOe                = sdaOe_reg;
	assign overcurrentTripLevel = tripLevel_reg;
	assign clipThresholdValue   = clipValue_reg;
	assign ampHalt              = ampHalt_reg;

endmodule : fsc_regs

// ### fsc_regs_asserts.sv
// Checker for fault flag and clip threshold behaviour at the register block ports.
`timescale 1ns/10ps
module fsc_regs_asserts (
	input wire logic                                clk,
	input wire logic                                reset,
	input wire logic                                sclIn,
	input wire logic                                sdaIn,
	input wire logic                                sdaOut,
	input wire logic                                sdaOe,
	input wire logic [6:0]                          deviceAddress,
	input wire logic                                ampShutdownPinN,
	input wire logic                                ampShutdownBit,
	input wire logic                                clockErrorDetect,
	input wire logic [fsc_pkg::FSC_CUR_W-1:0]       outputCurrent,
	input wire logic                                outputDcDetect,
	input wire logic                                overtempDetect,
	input wire logic [fsc_pkg::FSC_CLIP_HIGH_W-1:0] clipThresholdHigh,
	input wire fsc_pkg::fsc_fault_t                 faultStatus,
	input wire logic [fsc_pkg::FSC_CUR_W-1:0]       overcurrentTripLevel,
	input wire logic [fsc_pkg::FSC_CLIP_W-1:0]      clipThresholdValue,
	input wire logic                                ampHalt
);
	import fsc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	// Shutdown is a level, so any cycle with it active and no detector firing must empty the latches.
	wire shutActive = !ampShutdownPinN || !ampShutdownBit;
	clk_flag_follow_a: assert property (!$past(reset) |-> faultStatus.clockFaultFlag == $past(clockErrorDetect))
		else $error("clock flag does not follow the detector");
	oc_trip_set_a: assert property (outputCurrent > overcurrentTripLevel |=> faultStatus.overcurrentFaultFlag)
		else $error("overcurrent above trip level not flagged");
	dc_set_a: assert property (outputDcDetect |=> faultStatus.outputDcFaultFlag)
		else $error("dc error not flagged");
	ot_set_a: assert property (overtempDetect |=> faultStatus.overtempFaultFlag)
		else $error("overtemp not flagged");
	oc_latch_hold_a: assert property (faultStatus.overcurrentFaultFlag && !shutActive |=>
		faultStatus.overcurrentFaultFlag) else $error("overcurrent flag dropped without shutdown");
	dc_latch_hold_a: assert property (faultStatus.outputDcFaultFlag && !shutActive |=>
		faultStatus.outputDcFaultFlag) else $error("dc flag dropped without shutdown");
	ot_latch_hold_a: assert property (faultStatus.overtempFaultFlag && !shutActive |=>
		faultStatus.overtempFaultFlag) else $error("overtemp flag dropped without shutdown");
	latch_clear_a: assert property (shutActive && !outputDcDetect && !overtempDetect &&
		outputCurrent <= overcurrentTripLevel |=> faultStatus[2:0] == 3'h0) else $error("shutdown did not clear latches");
	trip_scale_a: assert property (overcurrentTripLevel inside {12'h800, 12'h600, 12'h400, 12'h200})
		else $error("trip level off the four scaled values");
	halt_on_fault_a: assert property (|faultStatus[2:0] |=> ampHalt)
		else $error("latched fault does not halt output");
	clip_high_a: assert property ($stable(clipThresholdHigh)[*3] |-> clipThresholdValue[19:14] == clipThresholdHigh)
		else $error("clip threshold top bits wrong");
endmodule : fsc_regs_asserts
bind fsc_regs fsc_regs_asserts u_chk (.clk, .reset, .sclIn, .sdaIn, .sdaOut, .sdaOe, .deviceAddress, .ampShutdownPinN,
	.ampShutdownBit, .clockErrorDetect, .outputCurrent, .outputDcDetect, .overtempDetect, .clipThresholdHigh,
	.faultStatus, .overcurrentTripLevel, .clipThresholdValue, .ampHalt);

// ### tb.sv
// Self-checking bench for the fault status and clip threshold registers.
`timescale 1ns/10ps
module tb;
	import fsc_pkg::*;
	logic                  clk              = 1'b0;
	logic                  reset            = 1'b1;
	logic                  ampShutdownPinN  = 1'b0;
	logic                  ampShutdownBit   = 1'b1;
	logic                  clockErrorDetect = 1'b0;
	logic [FSC_CUR_W-1:0]  outputCurrent    = 12'h0;
	logic                  outputDcDetect   = 1'b0;
	logic                  overtempDetect   = 1'b0;
	logic [5:0]            clipThresholdHigh = 6'h2a;
	logic [6:0]            deviceAddress    = 7'h2d;
	logic                  sclIn;
	logic                  hostLow;
	logic                  sdaOut;
	logic                  sdaOe;
	fsc_fault_t            faultStatus;
	logic [FSC_CUR_W-1:0]  overcurrentTripLevel;
	logic [FSC_CLIP_W-1:0] clipThresholdValue;
	logic                  ampHalt;
	int                    error_cnt = 0;
	int                    cmp_count = 0;
	// The data line has a pull-up; either party pulling low wins.
	wire sdaIn = !(hostLow || (sdaOe && !sdaOut));
	always #2 clk = !clk;
	fsc_regs u_dut (.clk, .reset, .sclIn, .sdaIn, .sdaOut, .sdaOe, .deviceAddress, .ampShutdownPinN, .ampShutdownBit,
		.clockErrorDetect, .outputCurrent, .outputDcDetect, .overtempDetect, .clipThresholdHigh, .faultStatus,
		.overcurrentTripLevel, .clipThresholdValue, .ampHalt);
	fsc_host_model u_host (.clk, .devAddr(deviceAddress), .sdaLine(sdaIn), .scl(sclIn), .sdaLow(hostLow));
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task automatic check(input string what, input logic [19:0] exp, input logic [19:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic ok;
		u_host.readReg(a, d, ok);
		check("readAck", 20'h1, {19'h0, ok});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ok;
		u_host.writeReg(a, d, ok);
		check("writeAck", 20'h1, {19'h0, ok});
	endtask : wr
	task automatic t_reset();
		logic [7:0] d;
		check("flags", 20'h0, {16'h0, faultStatus});
		check("trip", {8'h0, FSC_OC_NOMINAL}, {8'h0, overcurrentTripLevel});
		check("clip", {clipThresholdHigh, 8'h01, 6'h01}, clipThresholdValue);
		rd(FSC_ADDR_FAULT, d);
		check("faultReg", 20'h0, {12'h0, d});
		rd(FSC_ADDR_CLIP_LOW, d);
		check("clipLow", 20'h4, {12'h0, d});
		$display("reset test done");
	endtask : t_reset
	// Writes also set every status bit, which must not stick.
	task automatic t_trip();
		logic [7:0] d;
		for (int c = 0; c < 4; c++) begin
			wr(FSC_ADDR_FAULT, {2'h0, 2'(c), 4'hf});
			check("trip", {8'h0, 12'((FSC_OC_NOMINAL * (4 - c)) / 4)}, {8'h0, overcurrentTripLevel});
			rd(FSC_ADDR_FAULT, d);
			check("faultReg", {12'h0, 2'h0, 2'(c), 4'h0}, {12'h0, d});
		end
		$display("trip test done");
	endtask : t_trip
	// The upper six threshold bits come from outside, so they are moved once to prove they are carried through.
	task automatic t_clip();
		logic [7:0] d;
		wr(FSC_ADDR_CLIP_MID, 8'ha5);
		wr(FSC_ADDR_CLIP_LOW, 8'h5c);
		tick(2);
		check("clip", {clipThresholdHigh, 8'ha5, 6'h17}, clipThresholdValue);
		rd(FSC_ADDR_CLIP_LOW, d);
		check("clipLow", 20'h5c, {12'h0, d});
		clipThresholdHigh = 6'h15;
		tick(2);
		check("clipHigh", {6'h15, 8'ha5, 6'h17}, clipThresholdValue);
		$display("clip test done");
	endtask : t_clip
	// Trip level is 25 percent here, so a current at that level must not trip.
	task automatic t_faults();
		logic [7:0] d;
		ampShutdownPinN = 1'b1;
		outputCurrent = 12'h200;
		tick(3);
		check("ocAtLevel", 20'h0, {16'h0, faultStatus});
		outputCurrent = 12'h201;
		outputDcDetect = 1'b1;
		overtempDetect = 1'b1;
		clockErrorDetect = 1'b1;
		tick(1);
		outputCurrent = 12'h0;
		outputDcDetect = 1'b0;
		overtempDetect = 1'b0;
		tick(2);
		check("allFlags", 20'hf, {16'h0, faultStatus});
		check("halt", 20'h1, {19'h0, ampHalt});
		clockErrorDetect = 1'b0;
		tick(3);
		check("latched", 20'h7, {16'h0, faultStatus});
		rd(FSC_ADDR_FAULT, d);
		check("faultReg", 20'h37, {12'h0, d});
		ampShutdownPinN = 1'b0;
		tick(2);
		ampShutdownPinN = 1'b1;
		outputDcDetect = 1'b1;
		tick(1);
		outputDcDetect = 1'b0;
		tick(2);
		check("dcOnly", 20'h2, {16'h0, faultStatus});
		ampShutdownBit = 1'b0;
		tick(2);
		ampShutdownBit = 1'b1;
		tick(2);
		check("bitClear", 20'h0, {16'h0, faultStatus});
		$display("fault test done");
	endtask : t_faults
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : end_sim
	// Configuration runs with the shutdown pin low, as the host must.
	initial begin
		tick(4);
		reset = 1'b0;
		tick(2);
		t_reset();
		t_trip();
		t_clip();
		t_faults();
		end_sim();
	end
	// Guard against a hang anywhere in the sequence.
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		end_sim();
	end
endmodule : tb
